// ==== sim/tcat_far_model.sv ====
module tcat_far_model (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [tcat_pkg::NCH-1:0] lvl,
	input  wire logic                     clr,
	input  wire logic                     adc_trigger,
	output logic      [tcat_pkg::NCH-1:0] ch_in,
	output logic      [7:0]               trig_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [tcat_pkg::NCH-1:0] pin_r = '0;
	logic [7:0]               cnt_r = '0;
	// pins move only after a clock edge, like a synchronous source
	always @(posedge clk)
		pin_r <= lvl;
	// counting pulses exposes a trigger that is wider or repeated
	always @(posedge clk)
		if (rst || clr)
			cnt_r <= 8'h00;
		else if (adc_trigger)
			cnt_r <= cnt_r + 8'h01;
	assign ch_in      = pin_r;
	assign trig_count = cnt_r;
endmodule : tcat_far_model

// ==== sim/testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     clk       = 1'b0;
	logic                     rst       = 1'b1;
	logic [tcat_pkg::NCH-1:0] lvl       = '0;
	logic                     clr       = 1'b0;
	logic [tcat_pkg::AW-1:0]  reg_addr  = '0;
	logic [tcat_pkg::DW-1:0]  reg_wdata = '0;
	logic                     reg_wr    = 1'b0;
	logic                     reg_rd    = 1'b0;
	logic [tcat_pkg::DW-1:0]  reg_rdata;
	logic [tcat_pkg::CW-1:0]  shared_counter;
	logic                     adc_trigger;
	logic                     irq;
	logic [tcat_pkg::NCH-1:0] ch_in;
	logic [7:0]               trig_count;
	logic [15:0]              last;
	int                       fail_count = 0;
	int                       n_tests    = 0;

	initial forever #2 clk = ~clk;

	tcat_top dut (.clk(clk), .rst(rst), .ch_in(ch_in), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.shared_counter(shared_counter), .adc_trigger(adc_trigger), .irq(irq));
	tcat_far_model far (.clk(clk), .rst(rst), .lvl(lvl), .clr(clr),
		.adc_trigger(adc_trigger), .ch_in(ch_in), .trig_count(trig_count));

	task end_sim;
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= {16'h0000, d};
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr_reg

	// data stand only in the cycle after the strobe, so sample right there
	task rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & {16'h0000, m}, {16'h0000, e});
	endtask : rd_chk

	// counter held still so a capture has one exact expected value
	task set_cnt(input logic [15:0] v);
		wr_reg(tcat_pkg::OFS_INIT, v);
		wr_reg(tcat_pkg::OFS_COUNTER, 16'h0000);
	endtask : set_cnt

	task pin(input int n, input logic v);
		@(posedge clk);
		lvl[n] <= v;
		repeat (5) @(posedge clk);
	endtask : pin

	task t_reset;
		#1 chk({adc_trigger, irq}, 2'b00);
		rd_chk(tcat_pkg::OFS_MOD, 16'hFFFF, 16'hFFFF);
		rd_chk(tcat_pkg::OFS_MASK, 16'h00FF, 16'h00FF);
		rd_chk(8'h80, 16'hFFFF, 16'h0000);
		wr_reg(8'h80, 16'h1234);
		rd_chk(8'h80, 16'hFFFF, 16'h0000);
	endtask : t_reset

	task t_single;
		wr_reg(tcat_pkg::OFS_CTRL, 16'h0000);
		last = 16'h0000;
		for (int e = 1; e < 4; e++)
		begin
			wr_reg(8'h08, 16'h00C0 | 16'(e << 2));
			set_cnt(16'h1000 + 16'(e));
			pin(1, 1'b1);
			if (e[0])
				last = 16'h1000 + 16'(e);
			rd_chk(8'h08, 16'h0080, e[0] ? 16'h0080 : 16'h0000);
			rd_chk(8'h0C, 16'hFFFF, last);
			#1 chk(irq, e[0]);
			wr_reg(8'h08, 16'h00C0 | 16'(e << 2));
			set_cnt(16'h2000 + 16'(e));
			pin(1, 1'b0);
			if (e[1])
				last = 16'h2000 + 16'(e);
			rd_chk(8'h08, 16'h0080, e[1] ? 16'h0080 : 16'h0000);
			rd_chk(8'h0C, 16'hFFFF, last);
		end
		rd_chk(tcat_pkg::OFS_STATUS, 16'h0002, 16'h0002);
		wr_reg(tcat_pkg::OFS_MASK, 16'h0000);
		#1 chk(irq, 1'b0);
		wr_reg(tcat_pkg::OFS_MASK, 16'h00FF);
		#1 chk(irq, 1'b1);
		wr_reg(tcat_pkg::OFS_STATUS, 16'h0002);
		#1 chk(irq, 1'b0);
		wr_reg(tcat_pkg::OFS_CTRL, 16'h0100);
		pin(1, 1'b1);
		pin(1, 1'b0);
		rd_chk(8'h08, 16'h0080, 16'h0000);
		wr_reg(tcat_pkg::OFS_CTRL, 16'h1000);
		pin(1, 1'b1);
		pin(1, 1'b0);
		rd_chk(8'h08, 16'h0080, 16'h0000);
	endtask : t_single

	task t_dual(input logic cont);
		logic [15:0] a;
		wr_reg(8'h00, cont ? 16'h0014 : 16'h0004);
		wr_reg(8'h08, 16'h00C8);
		wr_reg(tcat_pkg::OFS_CTRL, 16'h0011);
		for (int k = 0; k <= int'(cont); k++)
		begin
			a = 16'h0100 + 16'(k * 16);
			set_cnt(a);
			pin(0, 1'b1);
			rd_chk(8'h04, 16'hFFFF, a);
			pin(1, 1'b1);
			pin(1, 1'b0);
			rd_chk(8'h08, 16'h0080, 16'h0000);
			set_cnt(a + 16'h0005);
			pin(0, 1'b0);
			rd_chk(8'h0C, 16'hFFFF, a + 16'h0005);
			rd_chk(8'h08, 16'h0080, 16'h0080);
			#1 chk(irq, 1'b1);
			rd_chk(tcat_pkg::OFS_CTRL, 16'h0010, cont ? 16'h0010 : 16'h0000);
			wr_reg(tcat_pkg::OFS_STATUS, 16'h00FF);
		end
	endtask : t_dual

	task t_trig;
		logic [7:0]  sel [7];
		logic [15:0] v;
		sel = '{8'h10, 8'h20, 8'h01, 8'h02, 8'h04, 8'h08, 8'h40};
		wr_reg(tcat_pkg::OFS_CTRL, 16'h0000);
		wr_reg(8'h00, 16'h0000);
		// the counter must start inside the window, or it first runs to the top of its range
		set_cnt(16'h0010);
		wr_reg(tcat_pkg::OFS_MOD, 16'h002F);
		for (int i = 0; i < 6; i++)
			wr_reg(8'(8 * i + 4), 16'h0018 + 16'(i));
		// both values of complementary pairs 0..2 stay free to place triggers
		wr_reg(tcat_pkg::OFS_CTRL, 16'h2700);
		for (int s = 0; s < 7; s++)
		begin
			v = (s < 6) ? 16'h0018 + 16'(s) : 16'h0010;
			wr_reg(tcat_pkg::OFS_TRIG, {8'h00, sel[s]});
			@(posedge clk);
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
			for (int c = 0; c < 32; c++)
			begin
				@(negedge clk);
				if (adc_trigger === 1'b1)
					chk(shared_counter, v);
			end
			// one more edge so the model has counted the last cycle looked at
			@(posedge clk);
			#1 chk(trig_count, 8'h01);
		end
	endtask : t_trig

	initial
	begin
		#300000;
		fail_count++;
		end_sim;
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_single;
		t_dual(1'b0);
		t_dual(1'b1);
		t_trig;
		end_sim;
	end
endmodule : testbench

// ==== verilog/tcat_edge_det.sv ====
module tcat_edge_det #(
	parameter int N = tcat_pkg::NCH
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [N-1:0] pin,
	output logic      [N-1:0] rise,
	output logic      [N-1:0] fall
);
	logic [N-1:0] prev_r;
	logic         valid_r;

	// no edge is reported on the first cycle after reset, when prev_r is not yet real
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prev_r  <= '0;
			valid_r <= 1'b0;
		end
		else
		begin
			prev_r  <= pin;
			valid_r <= 1'b1;
		end
	end

	assign rise = {N{valid_r}} & pin & ~prev_r;
	assign fall = {N{valid_r}} & ~pin & prev_r;
endmodule : tcat_edge_det

// ==== verilog/tcat_pkg.sv ====
package tcat_pkg;
	localparam int NCH   = 8;
	localparam int NPAIR = 4;
	localparam int NTRIG = 6;
	localparam int CW    = 16;
	localparam int AW    = 8;
	localparam int DW    = 32;

	// register offsets; channel n: status_control at 8*n, channel_value at 8*n + 4
	localparam logic [AW-1:0] OFS_CHAN_END = 8'h40;
	localparam logic [AW-1:0] OFS_COUNTER  = 8'h40;
	localparam logic [AW-1:0] OFS_INIT     = 8'h44;
	localparam logic [AW-1:0] OFS_MOD      = 8'h48;
	localparam logic [AW-1:0] OFS_CTRL     = 8'h4C;
	localparam logic [AW-1:0] OFS_TRIG     = 8'h50;
	localparam logic [AW-1:0] OFS_STATUS   = 8'h54;
	localparam logic [AW-1:0] OFS_MASK     = 8'h58;

	// channel_status_control fields
	localparam int SC_FLAG    = 7;
	localparam int SC_IRQ_EN  = 6;
	localparam int SC_MODE_LO = 4;
	localparam int SC_EDGE_LO = 2;

	// control register fields
	localparam int CTRL_DUAL_LO   = 0;
	localparam int CTRL_LAUNCH_LO = 4;
	localparam int CTRL_COMP_LO   = 8;
	localparam int CTRL_CENTER    = 12;
	localparam int CTRL_RUN       = 13;

	// conversion_trigger_select: bits 0..5 hold channels 2, 3, 4, 5, 0, 1, then the initial count bit
	localparam int TRIG_POS [NTRIG] = '{4, 5, 0, 1, 2, 3};
	localparam int TRIG_INIT        = 6;
	localparam logic [6:0] TRIG_CH5_SEL = 7'h08;

	localparam logic [CW-1:0]  MOD_RST  = 16'hFFFF;
	localparam logic [CW-1:0]  INIT_RST = 16'h0000;
	localparam logic [NCH-1:0] MASK_RST = 8'hFF;

	localparam logic [1:0] MODE_CAPTURE = 2'h0;
	localparam logic [1:0] EDGE_RISE    = 2'h1;
	localparam logic [1:0] EDGE_FALL    = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	typedef enum logic [1:0] {
		PAIR_IDLE   = 2'b00,
		PAIR_SECOND = 2'b01
	} tcat_pair_e;

	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		edge_hit = (sel[0] & rise) | (sel[1] & fall);
	endfunction : edge_hit
endpackage : tcat_pkg

// ==== verilog/tcat_top.sv ====
module tcat_top (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [tcat_pkg::NCH-1:0] ch_in,
	input  wire logic [tcat_pkg::AW-1:0] reg_addr,
	input  wire logic [tcat_pkg::DW-1:0] reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [tcat_pkg::DW-1:0] reg_rdata,
	output logic      [tcat_pkg::CW-1:0] shared_counter,
	output logic                         adc_trigger,
	output logic                         irq
);
	localparam int NCH = tcat_pkg::NCH;
	localparam int NP  = tcat_pkg::NPAIR;
	localparam int CW  = tcat_pkg::CW;
	localparam int AW  = tcat_pkg::AW;

	logic [CW-1:0]  cnt_r;
	logic [CW-1:0]  init_r;
	logic [CW-1:0]  mod_r;
	logic [CW-1:0]  cval_r [NCH];
	logic [1:0]     mode_r [NCH];
	logic [1:0]     edge_r [NCH];
	logic [NCH-1:0] ien_r;
	logic [NCH-1:0] flag_r;
	logic [NCH-1:0] mask_r;
	logic [NP-1:0]  dual_r;
	logic [NP-1:0]  launch_r;
	logic [NP-1:0]  comp_r;
	logic           center_r;
	logic           run_r;
	logic [6:0]     tsel_r;
	logic [tcat_pkg::DW-1:0] rdata_r;
	logic [tcat_pkg::DW-1:0] rdata_nxt;
	tcat_pkg::tcat_pair_e pair_r   [NP];
	tcat_pkg::tcat_pair_e pair_nxt [NP];

	logic [NCH-1:0] rise;
	logic [NCH-1:0] fall;
	logic [NCH-1:0] cap_en;
	logic [NCH-1:0] flag_set;
	logic [NCH-1:0] flag_clr;
	logic [NCH-1:0] wr_sc;
	logic [NCH-1:0] wr_val;
	logic [NCH-1:0] single_cap;
	logic [NP-1:0]  launch_clr;
	logic           wr_ctrl;

	tcat_edge_det #(
		.N (NCH)
	) u_edge (
		.clk  (clk),
		.rst  (rst),
		.pin  (ch_in),
		.rise (rise),
		.fall (fall)
	);

	tcat_trig_if u_trig_if (
		.clk (clk),
		.rst (rst)
	);

	assign u_trig_if.counter    = cnt_r;
	assign u_trig_if.init_value = init_r;
	assign u_trig_if.trig_sel   = tsel_r;
	assign u_trig_if.run        = run_r;

	// values of channels 0..5, even and odd, stay wired here so they can place triggers
	always_comb
	begin
		for (int c = 0; c < tcat_pkg::NTRIG; c++)
			u_trig_if.chan_value[c] = cval_r[c];
	end

	tcat_trig_gen u_trig (
		.t (u_trig_if.gen)
	);

	assign adc_trigger = u_trig_if.trigger;

	// register decode
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			wr_sc[c]  = reg_wr && reg_addr == AW'(8 * c);
			wr_val[c] = reg_wr && reg_addr == AW'(8 * c + 4);
		end
	end
	assign wr_ctrl = reg_wr && reg_addr == tcat_pkg::OFS_CTRL;

	// free running counter from the initial value up to the modulo
	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_r <= tcat_pkg::INIT_RST;
		else if (reg_wr && reg_addr == tcat_pkg::OFS_COUNTER)
			cnt_r <= init_r;
		else if (run_r)
			cnt_r <= (cnt_r == mod_r) ? init_r : cnt_r + 1'b1;
	end
	assign shared_counter = cnt_r;

	// capture path: single edge per channel, or a pair sharing the even pin
	always_comb
	begin
		cap_en     = '0;
		flag_set   = '0;
		launch_clr = '0;
		single_cap = '0;
		for (int p = 0; p < NP; p++)
		begin
			pair_nxt[p] = tcat_pkg::PAIR_IDLE;
			if (dual_r[p] && !center_r)
			begin
				// the odd pin is never looked at here
				if (launch_r[p])
				begin
					unique case (pair_r[p])
						tcat_pkg::PAIR_IDLE:
						begin
							if (tcat_pkg::edge_hit(edge_r[2*p], rise[2*p], fall[2*p]))
							begin
								cap_en[2*p]   = 1'b1;
								flag_set[2*p] = 1'b1;
								pair_nxt[p]   = tcat_pkg::PAIR_SECOND;
							end
						end
						tcat_pkg::PAIR_SECOND:
						begin
							pair_nxt[p] = tcat_pkg::PAIR_SECOND;
							if (tcat_pkg::edge_hit(edge_r[2*p+1], rise[2*p], fall[2*p]))
							begin
								cap_en[2*p+1]   = 1'b1;
								flag_set[2*p+1] = 1'b1;
								pair_nxt[p]     = tcat_pkg::PAIR_IDLE;
								launch_clr[p]   = !mode_r[2*p][0];
							end
						end
					endcase
				end
			end
			else
			begin
				for (int k = 0; k < 2; k++)
				begin
					// neither channel of a complementary pair captures outside dual mode
					single_cap[2*p+k] = mode_r[2*p+k] == tcat_pkg::MODE_CAPTURE && !center_r
						&& !comp_r[p];
					if (single_cap[2*p+k])
					begin
						if (tcat_pkg::edge_hit(edge_r[2*p+k], rise[2*p+k], fall[2*p+k]))
						begin
							cap_en[2*p+k]   = 1'b1;
							flag_set[2*p+k] = 1'b1;
						end
					end
					else if (run_r && cnt_r == cval_r[2*p+k])
						flag_set[2*p+k] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int p = 0; p < NP; p++)
				pair_r[p] <= tcat_pkg::PAIR_IDLE;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
				pair_r[p] <= pair_nxt[p];
		end
	end

	// channel values: a capture wins over a software write in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int c = 0; c < NCH; c++)
				cval_r[c] <= '0;
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (cap_en[c])
					cval_r[c] <= cnt_r;
				else if (wr_val[c])
					cval_r[c] <= reg_wdata[CW-1:0];
			end
		end
	end

	// channel control fields
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ien_r <= '0;
			for (int c = 0; c < NCH; c++)
			begin
				mode_r[c] <= tcat_pkg::MODE_CAPTURE;
				edge_r[c] <= 2'h0;
			end
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (wr_sc[c])
				begin
					ien_r[c]  <= reg_wdata[tcat_pkg::SC_IRQ_EN];
					mode_r[c] <= reg_wdata[tcat_pkg::SC_MODE_LO +: 2];
					edge_r[c] <= reg_wdata[tcat_pkg::SC_EDGE_LO +: 2];
				end
			end
		end
	end

	// event flags clear on a written one, in the channel or the status word
	always_comb
	begin
		flag_clr = '0;
		if (reg_wr && reg_addr == tcat_pkg::OFS_STATUS)
			flag_clr = reg_wdata[NCH-1:0];
		for (int c = 0; c < NCH; c++)
			if (wr_sc[c] && reg_wdata[tcat_pkg::SC_FLAG])
				flag_clr[c] = 1'b1;
	end

	// a new event outranks a clear landing in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			flag_r <= '0;
		else
			flag_r <= (flag_r & ~flag_clr) | flag_set;
	end

	// pair control; hardware may drop a launch bit unless software rewrites it now
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dual_r   <= '0;
			launch_r <= '0;
			comp_r   <= '0;
			center_r <= 1'b0;
			run_r    <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			dual_r   <= reg_wdata[tcat_pkg::CTRL_DUAL_LO +: NP];
			launch_r <= reg_wdata[tcat_pkg::CTRL_LAUNCH_LO +: NP];
			comp_r   <= reg_wdata[tcat_pkg::CTRL_COMP_LO +: NP];
			center_r <= reg_wdata[tcat_pkg::CTRL_CENTER];
			run_r    <= reg_wdata[tcat_pkg::CTRL_RUN];
		end
		else
			launch_r <= launch_r & ~launch_clr;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			init_r <= tcat_pkg::INIT_RST;
			mod_r  <= tcat_pkg::MOD_RST;
			tsel_r <= '0;
			mask_r <= tcat_pkg::MASK_RST;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				tcat_pkg::OFS_INIT: init_r <= reg_wdata[CW-1:0];
				tcat_pkg::OFS_MOD:  mod_r  <= reg_wdata[CW-1:0];
				tcat_pkg::OFS_TRIG: tsel_r <= reg_wdata[6:0];
				tcat_pkg::OFS_MASK: mask_r <= reg_wdata[NCH-1:0];
				default:            ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_nxt = '0;
		if (reg_addr < tcat_pkg::OFS_CHAN_END)
		begin
			if (reg_addr[2])
				rdata_nxt[CW-1:0] = cval_r[reg_addr[5:3]];
			else
			begin
				rdata_nxt[tcat_pkg::SC_FLAG]          = flag_r[reg_addr[5:3]];
				rdata_nxt[tcat_pkg::SC_IRQ_EN]        = ien_r[reg_addr[5:3]];
				rdata_nxt[tcat_pkg::SC_MODE_LO +: 2]  = mode_r[reg_addr[5:3]];
				rdata_nxt[tcat_pkg::SC_EDGE_LO +: 2]  = edge_r[reg_addr[5:3]];
			end
			if (reg_addr[1:0] != 2'h0)
				rdata_nxt = '0;
		end
		else
		begin
			unique case (reg_addr)
				tcat_pkg::OFS_COUNTER: rdata_nxt[CW-1:0] = cnt_r;
				tcat_pkg::OFS_INIT:    rdata_nxt[CW-1:0] = init_r;
				tcat_pkg::OFS_MOD:     rdata_nxt[CW-1:0] = mod_r;
				tcat_pkg::OFS_CTRL:
				begin
					rdata_nxt[tcat_pkg::CTRL_DUAL_LO +: NP]   = dual_r;
					rdata_nxt[tcat_pkg::CTRL_LAUNCH_LO +: NP] = launch_r;
					rdata_nxt[tcat_pkg::CTRL_COMP_LO +: NP]   = comp_r;
					rdata_nxt[tcat_pkg::CTRL_CENTER]          = center_r;
					rdata_nxt[tcat_pkg::CTRL_RUN]             = run_r;
				end
				tcat_pkg::OFS_TRIG:    rdata_nxt[6:0] = tsel_r;
				tcat_pkg::OFS_STATUS:  rdata_nxt[NCH-1:0] = flag_r;
				tcat_pkg::OFS_MASK:    rdata_nxt[NCH-1:0] = mask_r;
				default:               rdata_nxt = '0;
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_r <= '0;
		else
			rdata_r <= reg_rd ? rdata_nxt : '0;
	end
	assign reg_rdata = rdata_r;

	// both the per-channel enable and the mask must be open
	assign irq = |(flag_r & ien_r & mask_r);

	trig_ch5_a : assert property (@(posedge clk) disable iff (rst)
		(run_r && tsel_r == tcat_pkg::TRIG_CH5_SEL && cnt_r == cval_r[5]) |-> adc_trigger)
		else $error("channel 5 match gave no trigger");

	trig_ch0_a : assert property (@(posedge clk) disable iff (rst)
		(run_r && tsel_r[tcat_pkg::TRIG_POS[0]] && cnt_r == cval_r[0]) |-> adc_trigger)
		else $error("channel 0 match gave no trigger");

	trig_pulse_a : assert property (@(posedge clk) disable iff (rst)
		(adc_trigger && cnt_r != mod_r && !reg_wr) |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("trigger stood on an unchanged counter");

	cap_value_a : assert property (@(posedge clk) disable iff (rst)
		(single_cap[0] && rise[0] && edge_r[0] == tcat_pkg::EDGE_RISE)
		|=> cval_r[0] == $past(cnt_r) && flag_r[0])
		else $error("rising edge capture missed");

	fall_only_a : assert property (@(posedge clk) disable iff (rst)
		(single_cap[0] && fall[0] && edge_r[0] == tcat_pkg::EDGE_RISE && !wr_val[0])
		|=> $stable(cval_r[0]))
		else $error("falling edge captured in rise-only mode");

	both_edge_a : assert property (@(posedge clk) disable iff (rst)
		(single_cap[0] && fall[0] && edge_r[0] == tcat_pkg::EDGE_BOTH) |=> flag_r[0])
		else $error("both-edge mode missed a falling edge");

	irq_raise_a : assert property (@(posedge clk) disable iff (rst)
		($rose(flag_r[0]) && ien_r[0] && mask_r[0]) |-> irq)
		else $error("enabled flag raised no interrupt");

	odd_pin_a : assert property (@(posedge clk) disable iff (rst)
		(dual_r[0] && !center_r && (rise[1] || fall[1]) && !rise[0] && !fall[0]
		&& !wr_val[1]) |=> $stable(cval_r[1]))
		else $error("odd pin moved a dual capture");

	first_edge_a : assert property (@(posedge clk) disable iff (rst)
		(dual_r[0] && !center_r && launch_r[0] && pair_r[0] == tcat_pkg::PAIR_IDLE
		&& tcat_pkg::edge_hit(edge_r[0], rise[0], fall[0]))
		|=> pair_r[0] == tcat_pkg::PAIR_SECOND && cval_r[0] == $past(cnt_r))
		else $error("first edge not stored in even channel");

	one_shot_a : assert property (@(posedge clk) disable iff (rst)
		(cap_en[1] && dual_r[0] && !mode_r[0][0] && !wr_ctrl)
		|=> !launch_r[0] && flag_r[1])
		else $error("one-shot did not end after second edge");

	continuous_a : assert property (@(posedge clk) disable iff (rst)
		(cap_en[1] && dual_r[0] && mode_r[0][0] && !wr_ctrl)
		|=> launch_r[0] && flag_r[1] && pair_r[0] == tcat_pkg::PAIR_IDLE)
		else $error("continuous capture stopped");

	comp_odd_a : assert property (@(posedge clk) disable iff (rst)
		(comp_r[0] && !dual_r[0] && rise[1] && !wr_val[1]) |=> $stable(cval_r[1]))
		else $error("odd channel of complementary pair captured");
endmodule : tcat_top

// ==== verilog/tcat_trig_gen.sv ====
module tcat_trig_gen (
	tcat_trig_if.gen t
);
	logic [6:0] hit;

	always_comb
	begin
		hit = '0;
		for (int c = 0; c < tcat_pkg::NTRIG; c++)
			hit[tcat_pkg::TRIG_POS[c]] = (t.counter == t.chan_value[c]);
		hit[tcat_pkg::TRIG_INIT] = (t.counter == t.init_value);
	end

	// one cycle wide because the counter moves on every edge while running
	assign t.trigger = t.run & |(hit & t.trig_sel);

	trig_quiet_a : assert property (@(posedge t.clk) disable iff (t.rst)
		(!t.run || t.trig_sel == 7'h00) |-> !t.trigger)
		else $error("trigger with no enabled source");

	trig_init_a : assert property (@(posedge t.clk) disable iff (t.rst)
		(t.run && t.trig_sel[tcat_pkg::TRIG_INIT] && t.counter == t.init_value)
		|-> t.trigger)
		else $error("initial count match gave no trigger");
endmodule : tcat_trig_gen

// ==== verilog/tcat_trig_if.sv ====
interface tcat_trig_if (
	input wire logic clk,
	input wire logic rst
);
	logic [tcat_pkg::CW-1:0] counter;
	logic [tcat_pkg::CW-1:0] init_value;
	logic [tcat_pkg::CW-1:0] chan_value [tcat_pkg::NTRIG];
	logic [6:0]              trig_sel;
	logic                    run;
	logic                    trigger;

	modport src (input clk, rst, trigger, output counter, init_value, chan_value, trig_sel, run);
	modport gen (input clk, rst, counter, init_value, chan_value, trig_sel, run, output trigger);
endinterface : tcat_trig_if
